// File: hw/tbp_pkg.sv
// Package for the timer based pulse-width output block.
// Assumes a 32-bit APB slave, one clock, byte registers in the low lane.
package tbp_pkg;

  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_PERIOD_COUNTER   = 8'h00;
  localparam logic [7:0] ADDR_PERIOD_LIMIT     = 8'h04;
  localparam logic [7:0] ADDR_PERIOD_CTRL      = 8'h08;
  localparam logic [7:0] ADDR_DUTY_HIGH_1      = 8'h0C;
  localparam logic [7:0] ADDR_DUTY_ACTIVE_1    = 8'h10;
  localparam logic [7:0] ADDR_MODULE_CTRL_1    = 8'h14;
  localparam logic [7:0] ADDR_DUTY_HIGH_2      = 8'h18;
  localparam logic [7:0] ADDR_DUTY_ACTIVE_2    = 8'h1C;
  localparam logic [7:0] ADDR_MODULE_CTRL_2    = 8'h20;
  localparam logic [7:0] ADDR_STEERING         = 8'h24;
  localparam logic [7:0] ADDR_PERIPH_FLAGS     = 8'h28;
  localparam logic [7:0] ADDR_POWER_CTRL       = 8'h2C;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int RUN_BIT      = 2;  // Period timer run bit
  localparam int PRESCALE_LSB = 0;  // Prescale select bits 1:0
  localparam int POSTSCALE_LSB = 3; // Postscale select bits 6:3
  localparam int DUTY_LOW_LSB = 4;  // Duty low bits 5:4
  localparam int FLAG_BIT     = 1;  // Period timer flag
  localparam int SLEEP_BIT    = 0;  // Sleep request

  // ****************************************************************
  // Codes and reset values
  // ****************************************************************
  localparam logic [3:0] MODE_PWM_CODE  = 4'hC;  // Mode bits 11xx select modulation
  localparam logic [7:0] RESET_BYTE     = 8'h00;
  localparam logic [7:0] LIMIT_RESET    = 8'hFF;
  localparam logic [3:0] STEER_RESET    = 4'h1;
  localparam logic [1:0] PRE_DIV1       = 2'h0;
  localparam logic [1:0] PRE_DIV4       = 2'h1;
  localparam logic [3:0] PRE_LAST_DIV4  = 4'h3;
  localparam logic [3:0] PRE_LAST_DIV16 = 4'hF;

  // Output pair for one channel
  typedef struct packed {
    logic level;
    logic owned;
  } tbp_pin_type;

endpackage

// File: hw/tbp_pwm.sv
// Timer based pulse-width output with two channels and an APB slave.
// Assumes a synchronous APB master on clk; pins are muxed with port latches outside.
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps

module tbp_pwm (
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic      [3:0]            steeredOutput,
  output logic      [3:0]            steeredOwned,
  output tbp_pkg::tbp_pin_type       modulatedOutputPin
);
  import tbp_pkg::*;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] periodCounter;
  logic [7:0] periodLimit;
  logic [7:0] periodTimerControl;
  logic [7:0] dutyHigh    [2];
  logic [7:0] dutyActive  [2];
  logic [1:0] dutyLatch   [2];
  logic [7:0] moduleControl [2];
  logic [3:0] outputSteeringControl;
  logic       periodTimerFlag;
  logic       sleepMode;
  logic [3:0] prescaleCount;
  logic [1:0] clockPhase;
  logic       pinLevel [2];

  logic       access;
  logic       wrEn;
  logic       byteWr;
  logic       addrHit;
  logic       run;
  logic       tick;
  logic       baseStep;
  logic       rollover;
  logic [9:0] timeBase;
  logic [3:0] lastPrescale;
  logic       pwmOn [2];

  // Bus decode; one wait-free access phase
  assign access  = psel & penable;
  assign wrEn    = access & pwrite;
  assign byteWr  = wrEn & pstrb[0];
  assign pready  = 1'b1;
  assign pslverr = access & ~addrHit;

  // Timer advances only when running and awake
  assign run = periodTimerControl[RUN_BIT] & ~sleepMode;

  // Prescale terminal count; postscale field unused here
  always_comb begin
    case (periodTimerControl[PRESCALE_LSB +: 2])
      PRE_DIV1: lastPrescale = 4'h0;
      PRE_DIV4: lastPrescale = PRE_LAST_DIV4;
      default:  lastPrescale = PRE_LAST_DIV16;
    endcase
  end

  // One counter increment every four clocks times prescale
  assign tick = run && (clockPhase == 2'h3) && (prescaleCount == lastPrescale);
  assign rollover = tick && (periodCounter == periodLimit);

  // Ten-bit time base; low bits from phase at 1:1, prescaler bits 1:0 at 1:4, else prescaler bits 3:2
  always_comb begin
    if (periodTimerControl[PRESCALE_LSB +: 2] == PRE_DIV1) begin
      timeBase = {periodCounter, clockPhase};
    end else if (periodTimerControl[PRESCALE_LSB +: 2] == PRE_DIV4) begin
      timeBase = {periodCounter, prescaleCount[1:0]};
    end else begin
      timeBase = {periodCounter, prescaleCount[3:2]};
    end
  end

  // Edges at which the time base steps to its next value
  always_comb begin
    case (periodTimerControl[PRESCALE_LSB +: 2])
      PRE_DIV1: baseStep = run;
      PRE_DIV4: baseStep = run && (clockPhase == 2'h3);
      default:  baseStep = run && (clockPhase == 2'h3) && (prescaleCount[1:0] == 2'h3);
    endcase
  end

  // ****************************************************************
  // Time base counters
  // ****************************************************************
  // Clock phase and prescaler, cleared at rollover
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clockPhase    <= 2'h0;
      prescaleCount <= 4'h0;
    end else if (rollover) begin
      clockPhase    <= 2'h0;
      prescaleCount <= 4'h0;
    end else if (run) begin
      clockPhase <= clockPhase + 2'h1;
      if (clockPhase == 2'h3) begin
        prescaleCount <= (prescaleCount == lastPrescale) ? 4'h0 : prescaleCount + 4'h1;
      end
    end
  end

  // Period counter; software write wins over counting
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      periodCounter <= RESET_BYTE;
    end else if (byteWr && paddr == ADDR_PERIOD_COUNTER) begin
      periodCounter <= pwdata[7:0];
    end else if (rollover) begin
      periodCounter <= RESET_BYTE;
    end else if (tick) begin
      periodCounter <= periodCounter + 8'h01;
    end
  end

  // Control registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      periodLimit           <= LIMIT_RESET;
      periodTimerControl    <= RESET_BYTE;
      outputSteeringControl <= STEER_RESET;
      sleepMode             <= 1'b0;
    end else if (byteWr) begin
      case (paddr)
        ADDR_PERIOD_LIMIT: periodLimit           <= pwdata[7:0];
        ADDR_PERIOD_CTRL:  periodTimerControl    <= {1'b0, pwdata[6:0]};
        ADDR_STEERING:     outputSteeringControl <= pwdata[3:0];
        ADDR_POWER_CTRL:   sleepMode             <= pwdata[SLEEP_BIT];
        default: ;
      endcase
    end
  end

  // Period timer flag; overflow set wins over software clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      periodTimerFlag <= 1'b0;
    end else if (rollover) begin
      periodTimerFlag <= 1'b1;
    end else if (byteWr && paddr == ADDR_PERIPH_FLAGS) begin
      periodTimerFlag <= pwdata[FLAG_BIT];
    end
  end

  // ****************************************************************
  // Channels
  // ****************************************************************
  for (genvar ch = 0; ch < 2; ch++) begin : gChan
    logic [7:0] hiAddr;
    logic [7:0] actAddr;
    logic [7:0] ctlAddr;
    logic [9:0] dutyNew;
    assign hiAddr  = (ch == 0) ? ADDR_DUTY_HIGH_1 : ADDR_DUTY_HIGH_2;
    assign actAddr = (ch == 0) ? ADDR_DUTY_ACTIVE_1 : ADDR_DUTY_ACTIVE_2;
    assign ctlAddr = (ch == 0) ? ADDR_MODULE_CTRL_1 : ADDR_MODULE_CTRL_2;
    assign pwmOn[ch] = (moduleControl[ch][3:2] == MODE_PWM_CODE[3:2]);
    assign dutyNew = {dutyHigh[ch], moduleControl[ch][DUTY_LOW_LSB +: 2]};

    // Software side of the duty value, writable any time
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        dutyHigh[ch]      <= RESET_BYTE;
        moduleControl[ch] <= RESET_BYTE;
      end else if (byteWr && paddr == hiAddr) begin
        dutyHigh[ch] <= pwdata[7:0];
      end else if (byteWr && paddr == ctlAddr) begin
        moduleControl[ch] <= (ch == 0) ? pwdata[7:0] : {2'b00, pwdata[5:0]};
      end
    end

    // Active buffer and hidden latch, loaded at rollover
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        dutyActive[ch] <= RESET_BYTE;
        dutyLatch[ch]  <= 2'h0;
      end else if (rollover) begin
        dutyActive[ch] <= dutyNew[9:2];
        dutyLatch[ch]  <= dutyNew[1:0];
      end else if (byteWr && paddr == actAddr && !pwmOn[ch]) begin
        dutyActive[ch] <= pwdata[7:0];
      end
    end

    // Pin level: set at rollover unless zero duty, cleared on match
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        pinLevel[ch] <= 1'b0;
      end else if (!pwmOn[ch]) begin
        pinLevel[ch] <= 1'b0;
      end else if (rollover) begin
        pinLevel[ch] <= (dutyNew != 10'h000);
      end else if (baseStep && (timeBase + 10'h001) == {dutyActive[ch], dutyLatch[ch]}) begin
        // Clear on the edge at which the time base reaches the duty value
        pinLevel[ch] <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Pins
  // ****************************************************************
  // Channel one steered to four outputs; channel two on its own pin
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      steeredOutput            <= 4'h0;
      steeredOwned             <= 4'h0;
      modulatedOutputPin.level <= 1'b0;
      modulatedOutputPin.owned <= 1'b0;
    end else begin
      steeredOutput            <= outputSteeringControl & {4{pinLevel[0] & pwmOn[0]}};
      steeredOwned             <= outputSteeringControl & {4{pwmOn[0]}};
      modulatedOutputPin.level <= pinLevel[1] & pwmOn[1];
      modulatedOutputPin.owned <= pwmOn[1];
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb begin
    addrHit = 1'b1;
    prdata  = 32'h0000_0000;
    case (paddr)
      ADDR_PERIOD_COUNTER: prdata[7:0] = periodCounter;
      ADDR_PERIOD_LIMIT:   prdata[7:0] = periodLimit;
      ADDR_PERIOD_CTRL:    prdata[7:0] = periodTimerControl;
      ADDR_DUTY_HIGH_1:    prdata[7:0] = dutyHigh[0];
      ADDR_DUTY_ACTIVE_1:  prdata[7:0] = dutyActive[0];
      ADDR_MODULE_CTRL_1:  prdata[7:0] = moduleControl[0];
      ADDR_DUTY_HIGH_2:    prdata[7:0] = dutyHigh[1];
      ADDR_DUTY_ACTIVE_2:  prdata[7:0] = dutyActive[1];
      ADDR_MODULE_CTRL_2:  prdata[7:0] = moduleControl[1];
      ADDR_STEERING:       prdata[3:0] = outputSteeringControl;
      ADDR_PERIPH_FLAGS:   prdata[FLAG_BIT] = periodTimerFlag;
      ADDR_POWER_CTRL:     prdata[SLEEP_BIT] = sleepMode;
      default:             addrHit = 1'b0;
    endcase
  end

endmodule

// File: dv/tbp_pwm_sva.sv
// Port checker for the pulse-width output block.
// Assumes one clock domain and the register map of tbp_pkg.
`timescale 1ns/1ps
// ****************
// Checker module
// ****************
module tbp_pwm_sva
  import tbp_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 rst_b,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [3:0]           pstrb,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic [3:0]           steeredOutput,
  input wire logic [3:0]           steeredOwned,
  input wire tbp_pkg::tbp_pin_type modulatedOutputPin
);
  logic acc;
  // Access phase of a bus transfer
  assign acc = psel & penable;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Bus answers
  a_ready_high: assert property (acc |-> pready)
    else $error("pready low in access phase");
  a_err_unmapped: assert property (acc && paddr > ADDR_POWER_CTRL |-> pslverr)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (acc && paddr <= ADDR_POWER_CTRL && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  a_read_upper: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_ctrl_unimpl: assert property (acc && !pwrite && paddr == ADDR_PERIOD_CTRL |-> !prdata[7])
    else $error("timer control bit 7 reads one");
  a_ctrl2_unimpl: assert property (acc && !pwrite && paddr == ADDR_MODULE_CTRL_2 |-> prdata[7:6] == 2'h0)
    else $error("second control bits 7:6 read nonzero");
  // Pin ownership and waveform
  a_level_owned: assert property (modulatedOutputPin.level |-> modulatedOutputPin.owned)
    else $error("pin level high while released");
  a_steer_gate: assert property ((steeredOutput & ~steeredOwned) == 4'h0)
    else $error("unsteered output driven");
  a_min_period: assert property ($rose(modulatedOutputPin.level) |=> !$rose(modulatedOutputPin.level) [*3])
    else $error("pin period shorter than four clocks");
  a_release_pin: assert property (
    acc && pwrite && pstrb[0] && paddr == ADDR_MODULE_CTRL_2 && pwdata[7:0] == 8'h00
    |-> ##[1:2] !modulatedOutputPin.owned)
    else $error("pin not released after control cleared");
endmodule
bind tbp_pwm tbp_pwm_sva u_sva (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .steeredOutput(steeredOutput), .steeredOwned(steeredOwned), .modulatedOutputPin(modulatedOutputPin));

// File: dv/tbp_load.sv
// Load model on the second channel pin: measures period and high time.
// Assumes a pull-down on the pin while the block does not own it.
`timescale 1ns/1ps
module tbp_load (
  input wire logic                 clk,
  input wire tbp_pkg::tbp_pin_type pin,
  output int                       period,
  output int                       high,
  output int                       rises
);
  import tbp_pkg::*;
  int   cnt = 0;
  int   nRise = 0;
  logic wq = 1'b0;
  logic w;
  // Driver only active while owned, else pulled low
  assign w = pin.owned ? pin.level : 1'b0;
  assign rises = nRise;
  // Rising edges give period, falling edges give high time
  always @(posedge clk) begin
    cnt <= cnt + 1;
    if (w && !wq) begin
      period <= cnt;
      cnt    <= 1;
      nRise  <= nRise + 1;
    end
    if (!w && wq) high <= cnt;
    wq <= w;
  end
endmodule

// File: dv/testbench.sv
// Self-checking bench for the pulse-width output block over APB.
// Assumes zero-wait APB slave and the load model on channel two.
`timescale 1ns/1ps
module testbench;
  import tbp_pkg::*;
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, rd, tmp;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb, steeredOutput, steeredOwned;
  tbp_pin_type pin;
  int          period, high, rises, n_mismatch, n_tests, lim, duty, pre, pexp;
  tbp_pwm dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .steeredOutput(steeredOutput), .steeredOwned(steeredOwned), .modulatedOutputPin(pin));
  tbp_load load (.clk(clk), .pin(pin), .period(period), .high(high), .rises(rises));
  // ****************
  // Clock, tasks
  // ****************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      $display("Error %s expected %0h seen %0h", n, e, s);
      n_mismatch++;
    end
  endtask
  // One transfer after an idle cycle, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_rises(input int k);
    int r;
    r = rises;
    while (rises < r + k) @(posedge clk);
  endtask
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #300000;
    n_mismatch++;
    complete_run;
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    {rst_b, psel, penable, pwrite, err, paddr, rd, pwdata} = '0;
    pstrb = 4'hF;
    n_mismatch = 0;
    n_tests = 0;
    void'($urandom(32'h0b8f));
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, ADDR_PERIOD_LIMIT, 8'h00);
    chk("limit", LIMIT_RESET, rd);
    apb(1'b0, ADDR_STEERING, 8'h00);
    chk("steering", STEER_RESET, rd);
    chk("owned", 1'b0, pin.owned);
    apb(1'b0, 8'h30, 8'h00);
    chk("unmapped", 1'b1, err);
    $display("reset test done");
    // Period and high time for every prescale code
    for (int c = 0; c < 4; c++) begin
      lim = $urandom_range(7, 1);
      duty = $urandom_range(4 * lim + 3, 1);
      pre = (c == 0) ? 1 : ((c == 1) ? 4 : 16);
      pexp = (lim + 1) * 4 * pre;
      apb(1'b1, ADDR_PERIOD_LIMIT, 8'(lim));
      apb(1'b1, ADDR_PERIOD_COUNTER, 8'h00);
      apb(1'b1, ADDR_MODULE_CTRL_2, {2'h0, 2'(duty), 4'hC});
      apb(1'b1, ADDR_DUTY_HIGH_2, 8'(duty >> 2));
      apb(1'b1, ADDR_PERIPH_FLAGS, 8'h00);
      apb(1'b1, ADDR_PERIOD_CTRL, {1'b0, 4'($urandom_range(15, 0)), 1'b1, 2'(c)});
      wait_rises(3);
      chk("period", pexp, period);
      chk("high", duty * pre, high);
      apb(1'b1, ADDR_DUTY_ACTIVE_2, ~8'(duty >> 2));
      apb(1'b0, ADDR_DUTY_ACTIVE_2, 8'h00);
      chk("active", 8'(duty >> 2), rd);
    end
    $display("period test done");
    // Zero duty, then duty beyond the period
    apb(1'b1, ADDR_MODULE_CTRL_2, 8'h0C);
    apb(1'b1, ADDR_DUTY_HIGH_2, 8'h00);
    repeat (2 * pexp) @(posedge clk);
    lim = rises;
    repeat (2 * pexp) @(posedge clk);
    chk("zero duty", lim, rises);
    apb(1'b1, ADDR_MODULE_CTRL_2, 8'h3C);
    apb(1'b1, ADDR_DUTY_HIGH_2, 8'hFF);
    repeat (2 * pexp) @(posedge clk);
    chk("over duty", 1'b1, pin.level);
    apb(1'b0, ADDR_PERIPH_FLAGS, 8'h00);
    chk("flag", 1'b1, rd[FLAG_BIT]);
    $display("duty test done");
    // Stopped timer and sleep both freeze the counter
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, s ? ADDR_POWER_CTRL : ADDR_PERIOD_CTRL, s ? 8'h01 : 8'h00);
      apb(1'b0, ADDR_PERIOD_COUNTER, 8'h00);
      tmp = rd;
      repeat (40) @(posedge clk);
      apb(1'b0, ADDR_PERIOD_COUNTER, 8'h00);
      chk("frozen", tmp, rd);
      chk("held pin", 1'b1, pin.level);
      apb(1'b1, s ? ADDR_POWER_CTRL : ADDR_PERIOD_CTRL, s ? 8'h00 : 8'h04);
    end
    // Steering of channel one, then release of channel two
    apb(1'b1, ADDR_STEERING, 8'h0A);
    apb(1'b1, ADDR_DUTY_HIGH_1, 8'hFF);
    apb(1'b1, ADDR_MODULE_CTRL_1, 8'h0C);
    repeat (2 * pexp) @(posedge clk);
    chk("steered", 4'hA, steeredOwned);
    chk("steered out", 4'hA, steeredOutput);
    apb(1'b1, ADDR_MODULE_CTRL_2, 8'h00);
    repeat (2) @(posedge clk);
    chk("release", 1'b0, pin.owned);
    $display("control test done");
    complete_run;
  end
endmodule
